// >>> testbench/pcfp_pmem_model.sv
// program memory model answering one instruction word per fetch
`timescale 1ns/10ps
`default_nettype none

module pcfp_pmem_model (
    input  wire logic                 ref_clk,
    input  wire logic                 clk_en,
    input  wire logic                 slow,
    input  wire pcfp_pkg::pcfp_addr_t pm_addr_q,
    input  wire logic                 pm_rd_q,
    output var  pcfp_pkg::pcfp_word_t pm_rdata
);
    import pcfp_pkg::*;
    pcfp_word_t mem [0:63];
    pcfp_word_t word_q;
    logic [1:0] age_q;

    // word index drops bit zero: words sit on even byte addresses
    always_ff @(posedge ref_clk) begin
        if (clk_en && pm_rd_q) begin
            word_q <= mem[pm_addr_q[6:1]];
            age_q  <= 2'h1;
        end else if (clk_en && age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    // outside the valid window the bus carries the inverse, never stale data
    assign pm_rdata = (age_q == 2'h2 || (age_q == 2'h1 && !slow)) ?
                      word_q : ~word_q;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the fetch pipeline control core
`timescale 1ns/10ps
`default_nettype none
`include "pcfp_cfg.svh"

module tb;
    import pcfp_pkg::*;
    logic        ref_clk, rst, clk_en, reg_wr, reg_rd, slow;
    logic        exec_skip = 1'b0;
    logic        br_cond = 1'b1;
    logic        rd_pend = 1'b0;
    logic        ph_ok = 1'b0;
    logic [3:0]  ph_exp = 4'h0;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata_q, lath, program_counter_low_byte;
    logic [4:0]  latu;
    logic [11:0] opnd_q;
    logic        pm_rd_q, opnd_valid_q, data_rd_q, data_wr_q;
    pcfp_addr_t  pm_addr_q, exp_pc;
    pcfp_word_t  pm_rdata, exec_word_q;
    pcfp_kind_t  exec_kind_q;
    pcfp_phase_t phase_q;
    logic [31:0] q_fetch[$], q_rd[$], q_opnd[$], q_exec[$];
    int          n_fail = 0, tests_run = 0, seed = 38, n;
    // byte address in the top half, word in the bottom half
    logic [31:0] prog [17] = '{32'h0000_0F55, 32'h0002_0000, 32'h0004_EF08,
        32'h0006_F000, 32'h0008_2222, 32'h0010_D002, 32'h0012_1234,
        32'h0014_3333, 32'h0016_E002, 32'h0018_4444, 32'h001A_5555,
        32'h001C_C123, 32'h001E_F456, 32'h0020_6600, 32'h0022_C001,
        32'h0024_F789, 32'h0026_E005};
    logic [7:0]  fl [16] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h10, 8'h12,
        8'h16, 8'h18, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h26,
        8'h28, 8'h2A};
    // kind and word expected in the instruction latch, one per cycle
    logic [19:0] ex [16] = '{20'h0_0000, 20'h1_0F55, 20'h1_0000,
        20'h2_EF08, 20'h3_F000, 20'h1_D002, 20'h0_1234, 20'h1_E002,
        20'h0_4444, 20'h2_C123, 20'h3_F456, 20'h1_6600, 20'h0_C001,
        20'h0_F789, 20'h1_E005, 20'h1_0000};

    pcfp_core uut (.ref_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .pm_addr_q, .pm_rd_q, .pm_rdata,
        .br_cond, .exec_skip, .exec_word_q, .exec_kind_q, .opnd_q,
        .opnd_valid_q, .data_rd_q, .data_wr_q, .phase_q);
    pcfp_pmem_model pm (.ref_clk, .clk_en, .slow, .pm_addr_q, .pm_rd_q,
        .pm_rdata);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // an empty queue yields a value no output can carry
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        if (q.size() == 0)
            return 32'hDEAD_BEEF;
        return q.pop_front();
    endfunction

    task automatic results;
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one bus cycle; strobes are overwritten by the next call, not lowered
    task automatic bus(input logic w, r, input logic [1:0] a,
                       input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        q_rd.push_back({24'h0, e});
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic drain;
        n = 0;
        while (q_fetch.size() + q_rd.size() + q_opnd.size()
               + q_exec.size() != 0) begin
            @(posedge ref_clk);
            n++;
            if (n > 400) begin
                n_fail++;
                results();
            end
        end
    endtask

    // skip request and branch condition for the test words, as a flag unit
    // would; the second conditional branch must fall through
    always @(posedge ref_clk) begin
        exec_skip <= exec_word_q === 16'h6600 && exec_kind_q === kind_single;
        br_cond <= exec_word_q !== 16'hE005;
    end

    // monitor sees pre-edge outputs and retires the oldest notes
    always @(posedge ref_clk) begin
        if (ph_ok) chk(phase_q, ph_exp);
        ph_ok = ph_ok | rst;
        ph_exp = rst ? 4'h1 : (clk_en ? {ph_exp[2:0], ph_exp[3]} : ph_exp);
        if (rd_pend) chk(reg_rdata_q, pop(q_rd));
        rd_pend = reg_rd && clk_en && !rst;
        if (pm_rd_q) chk(phase_q, ph_two);
        if (pm_rd_q && clk_en && q_fetch.size() != 0)
            chk(pm_addr_q, pop(q_fetch));
        if (opnd_valid_q && clk_en && phase_q == ph_one)
            chk(opnd_q, pop(q_opnd));
        if (phase_q == ph_one && clk_en && !rst && q_exec.size() != 0)
            chk({exec_kind_q, exec_word_q}, pop(q_exec));
        if (data_rd_q) chk(phase_q, ph_two);
        if (data_wr_q) chk(phase_q, ph_four);
    end

    initial begin
        #1_000_000;
        n_fail++;
        results();
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        slow = 1'b1;
        foreach (pm.mem[i]) pm.mem[i] = 16'h0000;
        foreach (prog[i]) pm.mem[prog[i][22:17]] = prog[i][15:0];
        foreach (fl[i]) q_fetch.push_back({24'h0, fl[i]});
        q_opnd.push_back(32'h0000_0000);
        q_opnd.push_back(32'h0000_0456);
        foreach (ex[i]) q_exec.push_back({12'h0, ex[i]});
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (9) @(posedge ref_clk);
        clk_en <= 1'b0; // freeze in mid-fetch
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        drain();
        rd(`PCFP_REG_LATH, 8'h00);
        rd(`PCFP_REG_LATU, 8'h00);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        // clear the program so no jump lands on a random target
        foreach (pm.mem[i]) pm.mem[i] = 16'h0000;
        repeat (16) @(posedge ref_clk);
        for (int k = 0; k < 4; k++) begin
            lath = 8'($random(seed));
            latu = 5'($random(seed));
            program_counter_low_byte = 8'($random(seed));
            slow <= 1'($random(seed));
            bus(1'b1, 1'b0, `PCFP_REG_LATH, lath);
            bus(1'b1, 1'b0, `PCFP_REG_LATU, {3'h0, latu});
            bus(1'b0, 1'b0, 2'h0, 8'h00);
            // write in phase three, after this cycle's fetch went out, so the next fetch uses the new value
            n = 0;
            while (phase_q !== ph_two && n < 8) begin
                @(posedge ref_clk);
                n++;
            end
            if (phase_q !== ph_two) begin
                n_fail++;
                results();
            end
            bus(1'b1, 1'b0, `PCFP_REG_PCL, program_counter_low_byte);
            exp_pc = {latu, lath, program_counter_low_byte[7:1], 1'b0};
            q_fetch.push_back({11'h0, exp_pc});
            bus(1'b0, 1'b0, 2'h0, 8'h00);
            drain();
            exp_pc = exp_pc + 21'h0_0002;
            rd(`PCFP_REG_PCL, exp_pc[7:0]);
            rd(`PCFP_REG_LATH, exp_pc[15:8]);
            rd(`PCFP_REG_LATU, {3'h0, exp_pc[20:16]});
            bus(1'b0, 1'b0, 2'h0, 8'h00);
            drain();
        end
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        q_fetch.push_back(32'h0000_0000);
        rd(`PCFP_REG_LATH, 8'h00);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        drain();
        results();
    end
endmodule
`default_nettype wire

// >>> verilog/pcfp_cfg.svh
// constants of the program counter and fetch pipeline control
`ifndef PCFP_CFG_SVH
`define PCFP_CFG_SVH

// program counter geometry
`define PCFP_PC_W        21
`define PCFP_PC_RESET    21'h0_0000
`define PCFP_PC_STEP     21'h0_0002

// register port offsets
`define PCFP_REG_PCL     2'h0
`define PCFP_REG_LATH    2'h1
`define PCFP_REG_LATU    2'h2
`define PCFP_REG_STAT    2'h3

// opcode fields, compared against the top bits of a word
`define PCFP_OP_GOTO     8'hEF
`define PCFP_OP_CALL     7'h76
`define PCFP_OP_LPTR     8'hEE
`define PCFP_OP_FMOVE    4'hC
`define PCFP_OP_SECOND   4'hF
`define PCFP_OP_BRA      5'h1A
`define PCFP_OP_RELATIVE_CALL    5'h1B
`define PCFP_OP_BCOND    5'h1C

`endif

// >>> verilog/pcfp_core.sv
// program counter, latches and two-stage fetch/execute pipeline control
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pcfp_cfg.svh"

// Notes on behaviour
// - the program counter is a 21-bit byte address of the next fetch.
// - only the low byte is software visible; bits 20:8 are hidden.
// - counter bit zero is always zero, keeping fetches word aligned.
// - sequential fetch advances the counter by two bytes.
// - calls, gotos and branches load the counter; latches stay untouched.
// - a low byte write also loads both latches into bits 20:8.
// - a low byte read copies bits 20:8 into both latches.
// - the clock is divided by four into four one-hot phases.
// - counter steps in phase one; fetched word latched at phase four.
// - next fetch overlaps current execution; one cycle per word, two for a taken branch.
// - operand read strobe in phase two, destination write in phase four.
// - a relative branch or low byte write discards the prefetched word; takes two cycles.
// - instructions are one or two words on even byte addresses.
// - absolute call and goto write their word address to bits 20:1.
// - branch offsets count instruction words, not bytes.
// - move, call, goto, pointer load are two words; second starts 0xF.
// - a first word executing uses the next word's low 12 bits.
// - a second word reached on its own executes as a no-operation.
// - every reset starts fetching at address zero.
module pcfp_core (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    input  wire logic [1:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output var  logic [7:0]          reg_rdata_q,
    output var  pcfp_pkg::pcfp_addr_t pm_addr_q,
    output var  logic                pm_rd_q,
    input  wire pcfp_pkg::pcfp_word_t pm_rdata,
    input  wire logic                br_cond,
    input  wire logic                exec_skip,
    output var  pcfp_pkg::pcfp_word_t exec_word_q,
    output var  pcfp_pkg::pcfp_kind_t exec_kind_q,
    output var  logic [11:0]         opnd_q,
    output var  logic                opnd_valid_q,
    output var  logic                data_rd_q,
    output var  logic                data_wr_q,
    output var  pcfp_pkg::pcfp_phase_t phase_q
);
    import pcfp_pkg::*;

    pcfp_addr_t  pc_q;
    pcfp_addr_t  pc_d;
    logic [7:0]  lath_q;
    logic [7:0]  lath_d;
    logic [4:0]  latu_q;
    logic [4:0]  latu_d;
    pcfp_addr_t  instr_addr_q;
    logic        flush_pend_q;
    pcfp_kind_t  kind_in;

    // phase sequencer, the only divider of the input clock
    pcfp_phase_gen u_phase (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .phase_q (phase_q)
    );

    // phase enables, all frozen with the clock enable
    wire logic ph1 = clk_en & phase_q[0];
    wire logic ph3 = clk_en & phase_q[2];
    wire logic ph4 = clk_en & phase_q[3];

    // register port decode
    wire logic wr_pcl  = clk_en & reg_wr & (reg_addr == `PCFP_REG_PCL);
    wire logic wr_lath = clk_en & reg_wr & (reg_addr == `PCFP_REG_LATH);
    wire logic wr_latu = clk_en & reg_wr & (reg_addr == `PCFP_REG_LATU);
    wire logic rd_pcl  = clk_en & reg_rd & (reg_addr == `PCFP_REG_PCL);
    wire logic [12:0] pc_hi = pc_q[20:8];

    // decode of the word now executing
    wire logic executing = (exec_kind_q == kind_single)
                         | (exec_kind_q == kind_first);
    wire logic is_abs  = (exec_word_q[15:8] == `PCFP_OP_GOTO)
                       | (exec_word_q[15:9] == `PCFP_OP_CALL);
    wire logic rel_unc = (exec_word_q[15:11] == `PCFP_OP_BRA)
                       | (exec_word_q[15:11] == `PCFP_OP_RELATIVE_CALL);
    wire logic rel_cnd = (exec_word_q[15:11] == `PCFP_OP_BCOND);

    // control transfers decided at the end of the execute cycle
    wire logic abs_take  = ph4 & (exec_kind_q == kind_first) & is_abs;
    wire logic rel_take  = ph4 & (exec_kind_q == kind_single)
                         & (rel_unc | (rel_cnd & br_cond));
    wire logic skip_take = ph4 & (exec_kind_q == kind_single) & exec_skip;

    // word address of the goto target sits in two instruction words
    wire pcfp_addr_t abs_target = {pm_rdata[11:0], exec_word_q[7:0],
                                   1'b0};

    // offsets are in words, so they are doubled before the add
    wire pcfp_addr_t rel_words = rel_unc
        ? {{10{exec_word_q[10]}}, exec_word_q[10:0]}
        : {{13{exec_word_q[7]}}, exec_word_q[7:0]};
    wire pcfp_addr_t rel_bytes = {rel_words[19:0], 1'b0};
    wire pcfp_addr_t rel_target = instr_addr_q + `PCFP_PC_STEP
                                + rel_bytes;

    // the incoming word is discarded when the counter moved under it
    wire logic flush_in = flush_pend_q | wr_pcl | rel_take
                        | skip_take;

    // classification of the word arriving from program memory
    wire logic in_second = (pm_rdata[15:12] == `PCFP_OP_SECOND);
    wire logic in_first  = (pm_rdata[15:8] == `PCFP_OP_GOTO)
                         | (pm_rdata[15:9] == `PCFP_OP_CALL)
                         | (pm_rdata[15:8] == `PCFP_OP_LPTR)
                         | (pm_rdata[15:12] == `PCFP_OP_FMOVE);

    // a second word counts only right behind its own first word
    always_comb begin
        if (flush_in) begin
            kind_in = kind_nop;
        end else if (exec_kind_q == kind_first) begin
            kind_in = kind_second;
        end else if (in_second) begin
            kind_in = kind_nop;
        end else if (in_first) begin
            kind_in = kind_first;
        end else begin
            kind_in = kind_single;
        end
    end

    // counter next value: software write beats a jump beats the step
    always_comb begin
        if (wr_pcl) begin
            pc_d = {latu_q, lath_q, reg_wdata[7:1], 1'b0};
        end else if (abs_take) begin
            pc_d = abs_target;
        end else if (rel_take) begin
            pc_d = rel_target;
        end else if (ph1) begin
            pc_d = pc_q + `PCFP_PC_STEP;
        end else begin
            pc_d = pc_q;
        end
    end

    // latches follow software only; jumps never touch them
    always_comb begin
        if (wr_lath) begin
            lath_d = reg_wdata;
        end else if (rd_pcl) begin
            lath_d = pc_q[15:8];
        end else begin
            lath_d = lath_q;
        end
        if (wr_latu) begin
            latu_d = reg_wdata[4:0];
        end else if (rd_pcl) begin
            latu_d = pc_q[20:16];
        end else begin
            latu_d = latu_q;
        end
    end

    // read mux; the status byte shows pipeline state and phase
    wire logic [7:0] rd_mux =
        (reg_addr == `PCFP_REG_PCL)  ? pc_q[7:0] :
        (reg_addr == `PCFP_REG_LATH) ? lath_q :
        (reg_addr == `PCFP_REG_LATU) ? {3'b000, latu_q} :
        {1'b0, flush_pend_q, exec_kind_q, phase_q};

    // counter and latches; bit zero can only ever load zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc_q   <= `PCFP_PC_RESET;
            lath_q <= 8'h00;
            latu_q <= 5'h00;
        end else if (clk_en) begin
            pc_q   <= pc_d;
            lath_q <= lath_d;
            latu_q <= latu_d;
        end
    end

    // register read answer stands for one enabled cycle, then clears unless read again
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else if (clk_en) begin
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // a software write mid-cycle poisons the word fetched meanwhile
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flush_pend_q <= 1'b0;
        end else if (clk_en) begin
            flush_pend_q <= ph4 ? 1'b0 : (flush_pend_q | wr_pcl);
        end
    end

    // fetch stage: address issued at the end of phase one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pm_addr_q <= `PCFP_PC_RESET;
            pm_rd_q   <= 1'b0;
        end else if (clk_en) begin
            pm_rd_q <= phase_q[0];
            if (phase_q[0]) begin
                pm_addr_q <= pc_q;
            end
        end
    end

    // instruction latch loads at the end of phase four
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exec_word_q  <= 16'h0000;
            exec_kind_q  <= kind_nop;
            instr_addr_q <= `PCFP_PC_RESET;
            opnd_q       <= 12'h000;
            opnd_valid_q <= 1'b0;
        end else if (ph4) begin
            exec_word_q  <= pm_rdata;
            exec_kind_q  <= kind_in;
            instr_addr_q <= pm_addr_q;
            opnd_q       <= pm_rdata[11:0];
            opnd_valid_q <= (kind_in == kind_second);
        end
    end

    // data memory strobes: read in phase two, write in phase four
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_rd_q <= 1'b0;
            data_wr_q <= 1'b0;
        end else if (clk_en) begin
            data_rd_q <= phase_q[0] & executing;
            data_wr_q <= phase_q[2] & executing;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_fetch_run;
        (phase_q[0] && clk_en) ##1 clk_en [*2];
    endsequence

    sequence s_nop_cycle;
        (exec_kind_q == kind_nop) [*4];
    endsequence

    chk_reset_vector: assert property (
        $fell(rst) |-> (pc_q == `PCFP_PC_RESET && exec_kind_q == kind_nop))
        else $error("counter not at zero after reset");

    chk_pc_lsb_zero: assert property (
        pc_q[0] == 1'b0 && pm_addr_q[0] == 1'b0)
        else $error("counter bit zero not zero");

    chk_pc_step_two: assert property (
        (ph1 && !wr_pcl) |=> (pc_q == $past(pc_q) + `PCFP_PC_STEP
                              && pm_rd_q && pm_addr_q == $past(pc_q)))
        else $error("sequential fetch did not step by two");

    chk_pcl_write_load: assert property (
        wr_pcl |=> (pc_q[20:8] == {$past(latu_q), $past(lath_q)}
                    && pc_q[7:0] == ($past(reg_wdata) & 8'hFE)))
        else $error("low byte write did not load latches");

    chk_pcl_read_copy: assert property (
        (rd_pcl && !wr_lath && !wr_latu)
            |=> ({latu_q, lath_q} == $past(pc_hi)
                 && reg_rdata_q == $past(pc_q[7:0])))
        else $error("low byte read did not copy upper bits");

    chk_jump_latches: assert property (
        ((abs_take || rel_take) && !wr_lath && !wr_latu && !rd_pcl)
            |=> ($stable(lath_q) && $stable(latu_q)))
        else $error("jump disturbed the latches");

    chk_abs_target: assert property (
        (abs_take && !flush_in) |=> (pc_q == $past(abs_target)
                                   && exec_kind_q == kind_second))
        else $error("absolute target not loaded");

    chk_rel_flush: assert property (
        rel_take |=> s_nop_cycle)
        else $error("prefetched word not discarded");

    chk_second_nop: assert property (
        (ph4 && exec_kind_q != kind_first && in_second)
            |=> (exec_kind_q == kind_nop && !opnd_valid_q))
        else $error("lone second word not a no-operation");

    chk_two_word: assert property (
        (ph4 && exec_kind_q == kind_first && !flush_in)
            |=> (exec_kind_q == kind_second && opnd_valid_q
                 && opnd_q == $past(pm_rdata[11:0])))
        else $error("second word operand not taken");

    chk_phase_rot: assert property (
        s_fetch_run |=> phase_q[3])
        else $error("phases did not rotate by four");

    chk_data_strobes: assert property (
        (data_rd_q |-> phase_q[1]) and (data_wr_q |-> phase_q[3]))
        else $error("data strobe in wrong phase");
endmodule
`default_nettype wire

// >>> verilog/pcfp_phase_gen.sv
// divide-by-four quadrature phase generator
`timescale 1ns/10ps
`default_nettype none
`include "pcfp_cfg.svh"

module pcfp_phase_gen (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    output var  pcfp_pkg::pcfp_phase_t phase_q
);
    import pcfp_pkg::*;

    pcfp_phase_t phase_d;

    // rotate one phase per enabled clock; a corrupt code restarts at one
    always_comb begin
        unique case (phase_q)
            ph_one:   phase_d = ph_two;
            ph_two:   phase_d = ph_three;
            ph_three: phase_d = ph_four;
            ph_four:  phase_d = ph_one;
            default:  phase_d = ph_one;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= ph_one;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/pcfp_pkg.sv
// types shared by the fetch pipeline control files
package pcfp_pkg;
    typedef logic [20:0] pcfp_addr_t;
    typedef logic [15:0] pcfp_word_t;

    // what the word in the instruction latch is doing this cycle
    typedef enum logic [1:0] {
        kind_nop    = 2'b00,
        kind_single = 2'b01,
        kind_first  = 2'b10,
        kind_second = 2'b11
    } pcfp_kind_t;

    // one-hot quadrature phase within an instruction cycle
    typedef enum logic [3:0] {
        ph_one   = 4'b0001,
        ph_two   = 4'b0010,
        ph_three = 4'b0100,
        ph_four  = 4'b1000
    } pcfp_phase_t;
endpackage
